// ==== verilog/pcgdc_bank.sv ====
// Summary of operation
// RULE1: Gate bit 3 switches the edge enhancer and chroma reduction clock.
// RULE2: Gate bit 2 switches colour filter to 4:2:2, YCbCr histogram, boundary clock.
// RULE3: Gate bit 1 switches defect correction to white balance and raw histogram clock.
// RULE4: Gate bit 0 switches the boxcar clock; all gate bits reset to zero.
// RULE5: Software keeps the source format consistent with the enabled clock groups.
// RULE6: Software writes zero to reserved bits; they read back as zero.
// RULE7: Enable bit 0 turns table defect correction on; resets to zero.
// RULE8: Mode bit 1 selects a table of up to 1024 entries or unbounded.
// RULE9: Mode bit 0 picks black or white replacement for option zero entries.
// RULE10: Start register bits 9..0 hold the table start address; reset zero.
// RULE11: Entry count ignored when unbounded; otherwise count plus one entries valid.
// RULE12: A gated-off group holds its state and produces no new output.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module pcgdc_bank
   import pcgdc_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Clock group enables to the datapath gates
   output logic             edge_chroma_clock_on,
   output logic             color_stage_clock_on,
   output logic             raw_stage_clock_on,
   output logic             boxcar_clock_on,
   // Correction configuration
   output logic             lut_correction_enable,
   output logic             table_unbounded,
   output logic             replace_white,
   output logic [9:0]       lut_correction_start,
   output logic [10:0]      table_entry_limit
);
   pcgdc_cfg_if cfg ();

   logic [9:0] table_valid_count;

   // Bus slave
   pcgdc_apb_slave pcgdc_apb_slave_i (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pready  (pready),
      .prdata  (prdata),
      .pslverr (pslverr),
      .cfg     (cfg)
   );

   function automatic logic hit(input pcgdc_sel_type s);
      hit = cfg.wr_en && (cfg.wr_sel == s);
   endfunction

   // Clock gate enables; the datapath gates its clocks with these, holding stage state when off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {edge_chroma_clock_on, color_stage_clock_on, raw_stage_clock_on, boxcar_clock_on} <= pcgdc_gates_reset; // [RULE4]
      end else if (hit(pcgdc_sel_gates)) begin
         edge_chroma_clock_on <= cfg.wr_data[pcgdc_edge_bit];    // [RULE1] [RULE12]
         color_stage_clock_on <= cfg.wr_data[pcgdc_color_bit];   // [RULE2]
         raw_stage_clock_on   <= cfg.wr_data[pcgdc_raw_bit];     // [RULE3]
         boxcar_clock_on      <= cfg.wr_data[pcgdc_boxcar_bit];  // [RULE4]
      end
   end

   // Correction enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lut_correction_enable <= 1'b0;
      end else if (hit(pcgdc_sel_enable)) begin
         lut_correction_enable <= cfg.wr_data[pcgdc_enable_bit]; // [RULE7]
      end
   end

   // Correction mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_unbounded <= 1'b0;
         replace_white   <= 1'b0;
      end else if (hit(pcgdc_sel_mode)) begin
         table_unbounded <= cfg.wr_data[pcgdc_unbounded_bit]; // [RULE8]
         replace_white   <= cfg.wr_data[pcgdc_white_bit];     // [RULE9]
      end
   end

   // Table start address and entry count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lut_correction_start <= pcgdc_table_reset;
         table_valid_count    <= pcgdc_table_reset;
      end else begin
         if (hit(pcgdc_sel_start)) begin
            lut_correction_start <= cfg.wr_data[pcgdc_table_width-1:0]; // [RULE10]
         end
         if (hit(pcgdc_sel_count)) begin
            table_valid_count <= cfg.wr_data[pcgdc_table_width-1:0];
         end
      end
   end

   // Entry limit: zero means unbounded, else count plus one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_entry_limit <= 11'h001;
      end else if (table_unbounded) begin
         table_entry_limit <= 11'h000; // [RULE11]
      end else begin
         table_entry_limit <= {1'b0, table_valid_count} + 11'h001; // [RULE11]
      end
   end

   // Read mux; reserved bits read as zero
   always_comb begin
      cfg.rd_data = 32'h0000_0000; // [RULE6]
      unique case (cfg.rd_sel)
         pcgdc_sel_gates:  cfg.rd_data[3:0] = {edge_chroma_clock_on, color_stage_clock_on,
                                               raw_stage_clock_on, boxcar_clock_on};
         pcgdc_sel_enable: cfg.rd_data[0]   = lut_correction_enable;
         pcgdc_sel_mode:   cfg.rd_data[1:0] = {table_unbounded, replace_white};
         pcgdc_sel_start:  cfg.rd_data[9:0] = lut_correction_start;
         pcgdc_sel_count:  cfg.rd_data[9:0] = table_valid_count;
         default:          cfg.rd_data      = 32'h0000_0000;
      endcase
   end
endmodule // pcgdc_bank

// ==== verilog/pcgdc_pkg.sv ====
// Package with register map, field positions and reset values of the clock gate and correction bank
package pcgdc_pkg;
   // Register byte offsets
   localparam logic [11:0] pcgdc_gates_offset  = 12'h000;
   localparam logic [11:0] pcgdc_enable_offset = 12'h004;
   localparam logic [11:0] pcgdc_mode_offset   = 12'h008;
   localparam logic [11:0] pcgdc_start_offset  = 12'h00c;
   localparam logic [11:0] pcgdc_count_offset  = 12'h010;
   localparam int unsigned pcgdc_addr_width    = 12;
   // Field positions
   localparam int unsigned pcgdc_boxcar_bit     = 0;
   localparam int unsigned pcgdc_raw_bit        = 1;
   localparam int unsigned pcgdc_color_bit      = 2;
   localparam int unsigned pcgdc_edge_bit       = 3;
   localparam int unsigned pcgdc_gate_width     = 4;
   localparam int unsigned pcgdc_enable_bit     = 0;
   localparam int unsigned pcgdc_white_bit      = 0;
   localparam int unsigned pcgdc_unbounded_bit  = 1;
   localparam int unsigned pcgdc_table_width    = 10;
   localparam int unsigned pcgdc_bounded_max    = 1024;
   // Reset values
   localparam logic [3:0] pcgdc_gates_reset = 4'h0;
   localparam logic [9:0] pcgdc_table_reset = 10'h000;
   // Register selection
   typedef enum logic [2:0] {
      pcgdc_sel_gates  = 3'b000,
      pcgdc_sel_enable = 3'b001,
      pcgdc_sel_mode   = 3'b010,
      pcgdc_sel_start  = 3'b011,
      pcgdc_sel_count  = 3'b100,
      pcgdc_sel_none   = 3'b111
   } pcgdc_sel_type;
endpackage

// ==== verilog/pcgdc_cfg_if.sv ====
// Interface carrying register writes from the bus slave to the register bank
`timescale 1ns/1ps
interface pcgdc_cfg_if;
   import pcgdc_pkg::*;
   logic          wr_en;
   pcgdc_sel_type wr_sel;
   logic [31:0]   wr_data;
   logic [31:0]   rd_data;
   pcgdc_sel_type rd_sel;
   modport slave (output wr_en, output wr_sel, output wr_data, output rd_sel, input rd_data);
   modport bank  (input wr_en, input wr_sel, input wr_data, input rd_sel, output rd_data);
endinterface

// ==== verilog/pcgdc_apb_slave.sv ====
// APB slave that decodes addresses and forwards register writes and reads
`timescale 1ns/1ps
module pcgdc_apb_slave
   import pcgdc_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Bank side
   pcgdc_cfg_if.slave       cfg
);
   // Address decode
   function automatic pcgdc_sel_type decode(input logic [11:0] a);
      case (a)
         pcgdc_gates_offset:  decode = pcgdc_sel_gates;
         pcgdc_enable_offset: decode = pcgdc_sel_enable;
         pcgdc_mode_offset:   decode = pcgdc_sel_mode;
         pcgdc_start_offset:  decode = pcgdc_sel_start;
         pcgdc_count_offset:  decode = pcgdc_sel_count;
         default:             decode = pcgdc_sel_none;
      endcase
   endfunction

   logic setup;
   assign setup       = psel && !penable;
   // Writes take effect at the access edge
   assign cfg.wr_en   = psel && penable && pwrite && pready;
   assign cfg.wr_sel  = decode(paddr);
   assign cfg.wr_data = pwdata;
   assign cfg.rd_sel  = decode(paddr);

   // No wait states: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   // Read data captured during setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= cfg.rd_data;
      end
   end

   // Error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup && (decode(paddr) == pcgdc_sel_none);
      end
   end
endmodule // pcgdc_apb_slave

// ==== tb/pcgdc_bank_checker.sv ====
// Assertion checker for the clock gate and correction register bank
`timescale 1ns/1ps
module pcgdc_bank_checker
   import pcgdc_pkg::*;
(
   // Clock, reset and APB
   input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   // Configuration outputs
   input wire logic        edge_chroma_clock_on, color_stage_clock_on, raw_stage_clock_on, boxcar_clock_on,
   input wire logic        lut_correction_enable, table_unbounded, replace_white,
   input wire logic [9:0]  lut_correction_start,
   input wire logic [10:0] table_entry_limit
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed accesses by register
   wire acc = psel && penable && pready;
   wire wg  = acc && pwrite && paddr == pcgdc_gates_offset;
   wire wm  = acc && pwrite && paddr == pcgdc_mode_offset;
   wire ws  = acc && pwrite && paddr == pcgdc_start_offset;
   wire we  = acc && pwrite && paddr == pcgdc_enable_offset;
   wire wc  = acc && pwrite && paddr == pcgdc_count_offset;
   // Offsets outside the register map
   wire unmapped = !(paddr inside {pcgdc_gates_offset, pcgdc_enable_offset, pcgdc_mode_offset,
                                   pcgdc_start_offset, pcgdc_count_offset});
   sequence s_setup; psel && !penable; endsequence
   sequence s_quiet; !ws ##1 1'b1; endsequence
   a_ready_wait: assert property (s_setup |=> pready) else $error("no ready after setup");
   a_gate_edge: assert property (wg |=> edge_chroma_clock_on == $past(pwdata[3])) else $error("gate 3");
   a_gate_color: assert property (wg |=> color_stage_clock_on == $past(pwdata[2])) else $error("gate 2");
   a_gate_raw: assert property (wg |=> raw_stage_clock_on == $past(pwdata[1])) else $error("gate 1");
   a_gate_boxcar: assert property (wg |=> boxcar_clock_on == $past(pwdata[0])) else $error("gate 0");
   a_mode_table: assert property (wm |=> table_unbounded == $past(pwdata[1])) else $error("table type");
   a_mode_white: assert property (wm |=> replace_white == $past(pwdata[0])) else $error("dot polarity");
   a_start_addr: assert property (ws |=> lut_correction_start == $past(pwdata[9:0])) else $error("start");
   a_start_hold: assert property (s_quiet |-> $stable(lut_correction_start)) else $error("start moved");
   a_limit_unbnd: assert property (table_unbounded && $past(table_unbounded) |-> table_entry_limit == 11'h000)
      else $error("limit not ignored");
   a_reserved_zero: assert property (acc && !pwrite && paddr == pcgdc_gates_offset |-> prdata[31:4] == 28'h0)
      else $error("reserved bits");
   a_enable_bit: assert property (we |=> lut_correction_enable == $past(pwdata[0])) else $error("enable");
   a_limit_count: assert property (wc && !table_unbounded |=> ##1
      table_entry_limit == {1'b0, $past(pwdata[9:0], 2)} + 11'h001) else $error("limit not count plus one");
   a_unmapped_err: assert property (s_setup |=> pslverr == $past(unmapped)) else $error("slave error");
endmodule // pcgdc_bank_checker

bind pcgdc_bank pcgdc_bank_checker pcgdc_bank_checker_i (.*);

// ==== tb/pcgdc_bank_tb.sv ====
// Self-checking bench for the clock gate and correction register bank
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module pcgdc_bank_tb;
   import pcgdc_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, q, prdata;
   logic        pready, pslverr, err, e3, e2, e1, e0, en, tu, rw;
   logic [9:0]  st;
   logic [10:0] lim;
   int          n_mismatch = 0, cmp_count = 0;
   // Clock
   always #2.5 pclk = ~pclk;
   pcgdc_bank pcgdc_bank_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .edge_chroma_clock_on(e3), .color_stage_clock_on(e2), .raw_stage_clock_on(e1), .boxcar_clock_on(e0),
      .lut_correction_enable(en), .table_unbounded(tu), .replace_white(rw), .lut_correction_start(st),
      .table_entry_limit(lim));
   // Report and end of run
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One APB transfer, then time for the outputs to settle
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1 && ++n < 16);
      q = prdata; err = pslverr;
      if (n >= 16) n_mismatch++;
      psel <= 1'h0; penable <= 1'h0;
      repeat (3) @(posedge pclk);
   endtask
   // Test sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      xfer(0, pcgdc_gates_offset, 0); `CHK(q, 32'h0)
      xfer(0, pcgdc_enable_offset, 0); `CHK(q, 32'h0)
      xfer(0, pcgdc_start_offset, 0); `CHK(q, 32'h0)
      `CHK(lim, 11'h001)
      for (int i = 0; i < 4; i++) begin
         xfer(1, pcgdc_gates_offset, 32'h1 << i);
         `CHK({e3, e2, e1, e0}, 4'h1 << i)
         xfer(0, pcgdc_gates_offset, 0); `CHK(q, 32'h1 << i)
      end
      xfer(1, pcgdc_gates_offset, 32'h0000_000f);
      xfer(0, pcgdc_gates_offset, 0); `CHK(q, 32'h0000_000f)
      xfer(1, pcgdc_enable_offset, 32'h1); `CHK(en, 1'h1)
      xfer(1, pcgdc_mode_offset, 32'h1); `CHK({tu, rw}, 2'h1)
      xfer(1, pcgdc_start_offset, 32'h3ff); `CHK(st, 10'h3ff)
      xfer(1, pcgdc_start_offset, 32'h155); `CHK(st, 10'h155)
      xfer(1, pcgdc_count_offset, 32'h3ff); `CHK(lim, 11'h400)
      xfer(0, pcgdc_count_offset, 0); `CHK(q, 32'h3ff)
      xfer(1, pcgdc_mode_offset, 32'h2); `CHK({tu, rw}, 2'h2)
      `CHK(lim, 11'h000)
      xfer(0, pcgdc_mode_offset, 0); `CHK(q, 32'h2)
      `CHK(err, 1'h0)
      xfer(1, pcgdc_enable_offset, 32'h0); `CHK(en, 1'h0)
      xfer(0, 12'h014, 0); `CHK({err, q}, 33'h1_0000_0000)
      xfer(1, 12'h014, 32'h1); `CHK({err, e3, e2, e1, e0}, 5'h1f)
      // Reset in mid-run brings every register back
      presetn <= 1'h0;
      @(posedge pclk);
      presetn <= 1'h1;
      xfer(0, pcgdc_gates_offset, 0); `CHK(q, 32'h0)
      `CHK({tu, rw, en, st, lim}, 24'h000001)
      wrap_up();
   end
   // Watchdog
   initial begin
      #20us;
      n_mismatch++;
      wrap_up();
   end
endmodule // pcgdc_bank_tb
